// [include/bcs_pkg.sv]
package bcs_pkg;
  // widths
  localparam int AW = 24;
  localparam int DW = 16;
  localparam int NFLAG = 16;
  localparam int OFF13 = 13;
  localparam int OFF16 = 16;
  localparam int LC_W = 16;
  localparam logic [LC_W-1:0] LC_ONE = 16'h0001;
  // arithmetic status layout
  localparam int AST_W = 6;
  localparam int AB_Z = 0;
  localparam int AB_N = 1;
  localparam int AB_V = 2;
  localparam int AB_C = 3;
  localparam int AB_MV = 4;
  localparam int AB_SV = 5;
  // condition select codes
  localparam int CC_W = 5;
  localparam logic [CC_W-1:0] CC_AS = 5'h08;
  localparam logic [CC_W-1:0] CC_SV = 5'h09;
  localparam int CC_HI_BIT = 4;
  localparam int CC_GRP_BIT = 3;
  localparam int CC_IDX_W = 3;
  // condition field of an instruction
  localparam int COND_W = 4;
  localparam logic [COND_W-1:0] C_EQ = 4'h0;
  localparam logic [COND_W-1:0] C_NE = 4'h1;
  localparam logic [COND_W-1:0] C_GT = 4'h2;
  localparam logic [COND_W-1:0] C_LE = 4'h3;
  localparam logic [COND_W-1:0] C_LT = 4'h4;
  localparam logic [COND_W-1:0] C_GE = 4'h5;
  localparam logic [COND_W-1:0] C_AV = 4'h6;
  localparam logic [COND_W-1:0] C_NAV = 4'h7;
  localparam logic [COND_W-1:0] C_AC = 4'h8;
  localparam logic [COND_W-1:0] C_NAC = 4'h9;
  localparam logic [COND_W-1:0] C_SW = 4'hA;
  localparam logic [COND_W-1:0] C_NSW = 4'hB;
  localparam logic [COND_W-1:0] C_MV = 4'hC;
  localparam logic [COND_W-1:0] C_NMV = 4'hD;
  localparam logic [COND_W-1:0] C_TRUE = 4'hE;
  // instruction kinds
  localparam int KIND_W = 3;
  localparam logic [KIND_W-1:0] K_OP = 3'h0;
  localparam logic [KIND_W-1:0] K_J13 = 3'h1;
  localparam logic [KIND_W-1:0] K_JC16 = 3'h2;
  localparam logic [KIND_W-1:0] K_IND = 3'h3;
  localparam logic [KIND_W-1:0] K_LONG = 3'h4;
  localparam logic [KIND_W-1:0] K_LOOP = 3'h5;
  // loop termination codes
  localparam int TERM_W = 4;
  localparam logic [TERM_W-1:0] TERM_CE = 4'hE;
  localparam logic [TERM_W-1:0] TERM_FOREVER = 4'hF;
  // register port offsets
  localparam int RA_W = 4;
  localparam logic [RA_W-1:0] RA_ARITH_STATUS_REG = 4'h0;
  localparam logic [RA_W-1:0] RA_CC = 4'h1;
  localparam logic [RA_W-1:0] RA_FLAG = 4'h2;
  localparam logic [RA_W-1:0] RA_FDIR = 4'h3;
  localparam logic [RA_W-1:0] RA_FOUT = 4'h4;
  localparam logic [RA_W-1:0] RA_IST = 4'h5;
  localparam logic [RA_W-1:0] RA_IMASK = 4'h6;
  localparam logic [RA_W-1:0] RA_LCNT = 4'h7;
  // interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IB_BR = 0;
  localparam int IB_LEXIT = 1;
  localparam int IB_LBAD = 2;
  localparam int IB_SV = 3;
  // branch pipeline
  localparam int PIPE_DEPTH = 6;
  localparam int BR_LAT_ND = 4;
  localparam int BR_SAVE = 2;
  localparam int TAP_ND = BR_LAT_ND - 2;
  localparam int TAP_D = BR_LAT_ND - BR_SAVE - 2;
  typedef struct packed {
    logic v;
    logic dly;
    logic call;
    logic [AW-1:0] tgt;
  } bcs_br_t;
endpackage

// [verilog/bcs_cond.sv]
`timescale 1ns/100ps
module bcs_cond (
  // status and selection
  input wire logic [bcs_pkg::AST_W-1:0] ev_i,
  input wire logic [bcs_pkg::CC_W-1:0] cc_i,
  input wire logic [bcs_pkg::NFLAG-1:0] flags_i,
  // condition field
  input wire logic [bcs_pkg::COND_W-1:0] code_i,
  // results
  output logic sw_o,
  output logic true_o
);
  import bcs_pkg::*;

  logic lt;

  assign lt = ev_i[AB_N] ^ ev_i[AB_V];

  // selected software condition
  always_comb
  begin
    sw_o = 1'b0;
    if (cc_i == CC_AS)
      sw_o = ev_i[AB_N];
    else if (cc_i == CC_SV)
      sw_o = ev_i[AB_SV];
    else if (!cc_i[CC_GRP_BIT])
      sw_o = flags_i[{cc_i[CC_HI_BIT], cc_i[CC_IDX_W-1:0]}];
  end

  // directly encoded conditions, sign tests from N xor V, SW and NSW from sw_o
  always_comb
  begin
    case (code_i)
      C_EQ: true_o = ev_i[AB_Z];
      C_NE: true_o = !ev_i[AB_Z];
      C_GT: true_o = !(lt || ev_i[AB_Z]);
      C_LE: true_o = lt || ev_i[AB_Z];
      C_LT: true_o = lt;
      C_GE: true_o = !lt;
      C_AV: true_o = ev_i[AB_V];
      C_NAV: true_o = !ev_i[AB_V];
      C_AC: true_o = ev_i[AB_C];
      C_NAC: true_o = !ev_i[AB_C];
      C_SW: true_o = sw_o;
      C_NSW: true_o = !sw_o;
      C_MV: true_o = ev_i[AB_MV];
      C_NMV: true_o = !ev_i[AB_MV];
      C_TRUE: true_o = 1'b1;
      default: true_o = 1'b0;
    endcase
  end
endmodule // bcs_cond

// [verilog/bcs_seq.sv]
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module bcs_seq (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [bcs_pkg::RA_W-1:0] reg_addr_i,
  input wire logic [bcs_pkg::DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [bcs_pkg::DW-1:0] reg_rdata_o,
  // computational unit status
  input wire logic alu_upd_i,
  input wire logic alu_zero_i,
  input wire logic alu_neg_i,
  input wire logic alu_ovf_i,
  input wire logic alu_carry_i,
  input wire logic mult_upd_i,
  input wire logic mult_ovf_i,
  input wire logic shift_upd_i,
  input wire logic shift_ovf_i,
  // issued instruction
  input wire logic ins_valid_i,
  input wire logic [bcs_pkg::KIND_W-1:0] ins_kind_i,
  input wire logic [bcs_pkg::COND_W-1:0] ins_cond_i,
  input wire logic ins_call_i,
  input wire logic ins_delayed_i,
  input wire logic [bcs_pkg::AW-1:0] ins_pc_i,
  input wire logic [bcs_pkg::AW-1:0] ins_imm_i,
  input wire logic [bcs_pkg::TERM_W-1:0] ins_term_i,
  input wire logic [bcs_pkg::DW-1:0] dag_i,
  input wire logic loop_last_i,
  // sequencing results
  output logic exec_o,
  output logic suppress_o,
  output logic redirect_o,
  output logic redirect_call_o,
  output logic [bcs_pkg::AW-1:0] redirect_addr_o,
  output logic flush_o,
  output logic loop_back_o,
  output logic loop_exit_o,
  // flag pins
  input wire logic [bcs_pkg::NFLAG-1:0] flag_i,
  output logic [bcs_pkg::NFLAG-1:0] flag_o,
  output logic [bcs_pkg::NFLAG-1:0] flag_oe_o,
  // interrupt
  output logic irq_o
);
  import bcs_pkg::*;

  typedef struct packed {
    logic [AST_W-1:0] arith_status_reg;
    logic [AST_W-1:0] ev;
    logic aw_d;
    logic [CC_W-1:0] cc;
    logic [CC_W-1:0] cc_ev;
    logic [NFLAG-1:0] fdir;
    logic [NFLAG-1:0] fout;
    logic [NFLAG-1:0] fs1;
    logic [NFLAG-1:0] fs2;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
    logic irq;
    logic [DW-1:0] rdata;
    logic [LC_W-1:0] lcnt;
    logic lact;
    logic lfor;
    bcs_br_t [PIPE_DEPTH-1:0] pipe;
    logic exec;
    logic supp;
    logic redir;
    logic rcall;
    logic [AW-1:0] raddr;
    logic flush;
    logic lback;
    logic lexit;
  } bcs_st_t;

  bcs_st_t s_r, s_nxt;
  logic [NFLAG-1:0] fstate;
  logic sw_w, cond_true;
  logic isbr, iscond, take_w, ent_dly, fire_nd, fire_d, line_empty;
  logic [AW-1:0] tgt_w;
  logic [PIPE_DEPTH-1:0] vbits;
  bcs_br_t ent_w;

  // register port decode
  function automatic logic wr_hit(input logic [RA_W-1:0] a);
    return reg_wr_i && (reg_addr_i == a);
  endfunction

  function automatic logic rd_hit(input logic [RA_W-1:0] a);
    return reg_rd_i && (reg_addr_i == a);
  endfunction

  // unit results land in status copies
  function automatic logic [AST_W-1:0] apply_units(input logic [AST_W-1:0] st);
    logic [AST_W-1:0] r;
    r = st;
    if (alu_upd_i)
    begin
      r[AB_Z] = alu_zero_i;
      r[AB_N] = alu_neg_i;
      r[AB_V] = alu_ovf_i;
      r[AB_C] = alu_carry_i;
    end
    if (mult_upd_i)
      r[AB_MV] = mult_ovf_i;
    if (shift_upd_i)
      r[AB_SV] = shift_ovf_i;
    return r;
  endfunction

  // pin state: outputs read back, inputs after two flops
  assign fstate = (s_r.fdir & s_r.fout) | (~s_r.fdir & s_r.fs2);

  bcs_cond u_cond (
    .ev_i(s_r.ev),
    .cc_i(s_r.cc_ev),
    .flags_i(fstate),
    .code_i(ins_cond_i),
    .sw_o(sw_w),
    .true_o(cond_true)
  );

  // branch decode
  assign isbr = ins_valid_i && (ins_kind_i == K_J13 || ins_kind_i == K_JC16 ||
                ins_kind_i == K_IND || ins_kind_i == K_LONG);
  assign iscond = ins_valid_i && (ins_kind_i == K_OP || ins_kind_i == K_J13 ||
                  ins_kind_i == K_IND || ins_kind_i == K_LONG);
  assign fire_nd = s_r.pipe[TAP_ND].v && !s_r.pipe[TAP_ND].dly;
  assign fire_d = s_r.pipe[TAP_D].v && s_r.pipe[TAP_D].dly;
  assign take_w = isbr && (ins_kind_i == K_JC16 || cond_true) && !fire_nd;
  assign ent_dly = ins_delayed_i && (ins_kind_i != K_LONG);

  // branch target
  assign tgt_w = (ins_kind_i == K_J13) ?
                   ins_pc_i + {{(AW-OFF13){ins_imm_i[OFF13-1]}}, ins_imm_i[OFF13-1:0]} :
                 (ins_kind_i == K_JC16) ?
                   ins_pc_i + {{(AW-OFF16){ins_imm_i[OFF16-1]}}, ins_imm_i[OFF16-1:0]} :
                 (ins_kind_i == K_IND) ? {ins_pc_i[AW-1:DW], dag_i} :
                 ins_imm_i;

  assign ent_w.v = take_w;
  assign ent_w.dly = ent_dly;
  assign ent_w.call = ins_call_i && (ins_kind_i != K_J13);
  assign ent_w.tgt = tgt_w;

  // pipeline occupancy
  genvar g;
  generate
    for (g = 0; g < PIPE_DEPTH; g++)
    begin : g_occ
      assign vbits[g] = s_r.pipe[g].v;
    end
  endgenerate
  assign line_empty = ~|vbits;

  always_comb
  begin
    logic lbad;
    logic [IRQ_W-1:0] evts;
    lbad = 1'b0;
    evts = '0;
    s_nxt = s_r;
    // flag input synchroniser
    s_nxt.fs1 = flag_i;
    s_nxt.fs2 = s_r.fs1;
    // arithmetic status, test copy lags software writes
    s_nxt.aw_d = wr_hit(RA_ARITH_STATUS_REG);
    s_nxt.ev = s_r.aw_d ? s_r.arith_status_reg : s_r.ev;
    if (wr_hit(RA_ARITH_STATUS_REG))
      s_nxt.arith_status_reg = reg_wdata_i[AST_W-1:0];
    s_nxt.arith_status_reg = apply_units(s_nxt.arith_status_reg);
    s_nxt.ev = apply_units(s_nxt.ev);
    // condition select, test copy one cycle behind
    if (wr_hit(RA_CC))
      s_nxt.cc = reg_wdata_i[CC_W-1:0];
    s_nxt.cc_ev = s_r.cc;
    // flag and mask registers
    if (wr_hit(RA_FDIR))
      s_nxt.fdir = reg_wdata_i[NFLAG-1:0];
    if (wr_hit(RA_FOUT))
      s_nxt.fout = reg_wdata_i[NFLAG-1:0];
    if (wr_hit(RA_IMASK))
      s_nxt.imask = reg_wdata_i[IRQ_W-1:0];
    // branch redirect, non-delayed wins and flushes its shadow
    s_nxt.redir = 1'b0;
    s_nxt.rcall = 1'b0;
    s_nxt.flush = 1'b0;
    if (fire_nd)
    begin
      s_nxt.redir = 1'b1;
      s_nxt.rcall = s_r.pipe[TAP_ND].call;
      s_nxt.raddr = s_r.pipe[TAP_ND].tgt;
      s_nxt.flush = 1'b1;
      s_nxt.pipe = '0;
    end
    else
    begin
      if (fire_d)
      begin
        s_nxt.redir = 1'b1;
        s_nxt.rcall = s_r.pipe[TAP_D].call;
        s_nxt.raddr = s_r.pipe[TAP_D].tgt;
      end
      for (int k = PIPE_DEPTH - 1; k > 0; k--)
        s_nxt.pipe[k] = s_r.pipe[k-1];
      s_nxt.pipe[0] = ent_w;
    end
    // conditional execution
    s_nxt.exec = ins_valid_i && (ins_kind_i == K_OP) && cond_true && !fire_nd;
    s_nxt.supp = iscond && !cond_true && !fire_nd;
    // hardware loop
    s_nxt.lback = 1'b0;
    s_nxt.lexit = 1'b0;
    if (ins_valid_i && (ins_kind_i == K_LOOP) && !fire_nd)
    begin
      if (ins_term_i == TERM_CE)
      begin
        s_nxt.lact = 1'b1;
        s_nxt.lfor = 1'b0;
        s_nxt.lcnt = ins_imm_i[LC_W-1:0];
      end
      else if (ins_term_i == TERM_FOREVER)
      begin
        s_nxt.lact = 1'b1;
        s_nxt.lfor = 1'b1;
      end
      else
        lbad = 1'b1;
    end
    else if (loop_last_i && s_r.lact)
    begin
      if (s_r.lfor)
        s_nxt.lback = 1'b1;
      else if (s_r.lcnt <= LC_ONE)
      begin
        s_nxt.lexit = 1'b1;
        s_nxt.lact = 1'b0;
      end
      else
      begin
        s_nxt.lcnt = s_r.lcnt - LC_ONE;
        s_nxt.lback = 1'b1;
      end
    end
    // sticky events, read clears, set wins
    evts[IB_BR] = s_nxt.redir;
    evts[IB_LEXIT] = s_nxt.lexit;
    evts[IB_LBAD] = lbad;
    evts[IB_SV] = shift_upd_i && shift_ovf_i;
    s_nxt.ist = (rd_hit(RA_IST) ? '0 : s_r.ist) | evts;
    s_nxt.irq = |(s_nxt.ist & s_nxt.imask);
    // read data, one cycle after the strobe
    s_nxt.rdata = '0;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        RA_ARITH_STATUS_REG: s_nxt.rdata = DW'(s_r.arith_status_reg);
        RA_CC: s_nxt.rdata = DW'(s_r.cc);
        RA_FLAG: s_nxt.rdata = fstate;
        RA_FDIR: s_nxt.rdata = s_r.fdir;
        RA_FOUT: s_nxt.rdata = s_r.fout;
        RA_IST: s_nxt.rdata = DW'(s_r.ist);
        RA_IMASK: s_nxt.rdata = DW'(s_r.imask);
        RA_LCNT: s_nxt.rdata = s_r.lcnt;
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  // all state clears to zero
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign reg_rdata_o = s_r.rdata;
  assign exec_o = s_r.exec;
  assign suppress_o = s_r.supp;
  assign redirect_o = s_r.redir;
  assign redirect_call_o = s_r.rcall;
  assign redirect_addr_o = s_r.raddr;
  assign flush_o = s_r.flush;
  assign loop_back_o = s_r.lback;
  assign loop_exit_o = s_r.lexit;
  assign flag_o = s_r.fout;
  assign flag_oe_o = s_r.fdir;
  assign irq_o = s_r.irq;

  // checks
  logic [CC_W-1:0] wd_cc;
  logic no_upd;
  assign wd_cc = reg_wdata_i[CC_W-1:0];
  assign no_upd = !alu_upd_i && !mult_upd_i && !shift_upd_i;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_stat_lat;
    wr_hit(RA_ARITH_STATUS_REG) && no_upd |=> s_r.ev == $past(s_r.ev);
  endproperty
  a_stat_lat: assert property (p_stat_lat) else $error("status write seen too early");

  property p_sv;
    shift_upd_i |=> s_r.arith_status_reg[AB_SV] == $past(shift_ovf_i);
  endproperty
  a_sv: assert property (p_sv) else $error("shift overflow bit wrong");

  property p_eq;
    ins_valid_i && ins_kind_i == K_OP && ins_cond_i == C_EQ && !fire_nd
      |=> exec_o == $past(s_r.ev[AB_Z]);
  endproperty
  a_eq: assert property (p_eq) else $error("equal condition not from zero bit");

  property p_cc9;
    ins_valid_i && ins_kind_i == K_OP && ins_cond_i == C_SW && s_r.cc_ev == CC_SV && !fire_nd
      |=> exec_o == $past(s_r.ev[AB_SV]);
  endproperty
  a_cc9: assert property (p_cc9) else $error("select 0x09 not shift overflow");

  property p_cc_lat;
    wr_hit(RA_CC) |-> ##2 s_r.cc_ev == $past(wd_cc, 2);
  endproperty
  a_cc_lat: assert property (p_cc_lat) else $error("select latency wrong");

  property p_nsw;
    ins_valid_i && ins_kind_i == K_OP && ins_cond_i == C_NSW && !fire_nd
      |=> exec_o == !$past(sw_w);
  endproperty
  a_nsw: assert property (p_nsw) else $error("inverted software condition wrong");

  property p_flag;
    rd_hit(RA_FLAG) |=> reg_rdata_o == $past(fstate);
  endproperty
  a_flag: assert property (p_flag) else $error("flag state read wrong");

  property p_nd;
    take_w && !ent_dly && line_empty |-> ##4 redirect_o && flush_o;
  endproperty
  a_nd: assert property (p_nd) else $error("non-delayed branch latency wrong");

  property p_dl;
    take_w && ent_dly && line_empty |=> !redirect_o ##1 redirect_o && !flush_o;
  endproperty
  a_dl: assert property (p_dl) else $error("delayed branch latency wrong");

  property p_long;
    take_w && ins_kind_i == K_LONG && line_empty |-> ##4 redirect_addr_o == $past(ins_imm_i, 4);
  endproperty
  a_long: assert property (p_long) else $error("long target wrong");

  property p_false;
    iscond && !cond_true && !fire_nd |=> suppress_o && !exec_o;
  endproperty
  a_false: assert property (p_false) else $error("false condition not suppressed");

  property p_loop;
    ins_valid_i && ins_kind_i == K_LOOP && ins_term_i != TERM_CE &&
      ins_term_i != TERM_FOREVER && !fire_nd |=> s_r.ist[IB_LBAD] && $stable(s_r.lcnt);
  endproperty
  a_loop: assert property (p_loop) else $error("bad loop termination accepted");

  c_delayed: cover property (redirect_o && !flush_o);
  c_flush: cover property (redirect_o && flush_o);
  c_lexit: cover property (loop_exit_o);
  c_irq: cover property (irq_o && suppress_o);
endmodule // bcs_seq

// [testbench/bcs_unit_model.sv]
`timescale 1ns/100ps
module bcs_unit_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench requests
  input wire logic [2:0] upd_i,
  input wire logic [bcs_pkg::AST_W-1:0] st_i,
  input wire logic [bcs_pkg::NFLAG-1:0] ext_i,
  // unit status lines
  output logic alu_upd_o,
  output logic [3:0] alu_st_o,
  output logic mult_upd_o,
  output logic mult_ovf_o,
  output logic shift_upd_o,
  output logic shift_ovf_o,
  // flag pins
  input wire logic [bcs_pkg::NFLAG-1:0] drv_i,
  input wire logic [bcs_pkg::NFLAG-1:0] oe_i,
  output logic [bcs_pkg::NFLAG-1:0] pin_o
);
  import bcs_pkg::*;
  logic [AST_W-1:0] last_r;
  logic [AST_W-1:0] mask;
  logic [AST_W-1:0] bus;
  assign mask = {upd_i[2], upd_i[1], {4{upd_i[0]}}};
  // status lines not being loaded toggle, never hold the last value
  assign bus = (st_i & mask) | (~last_r & ~mask);
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      last_r <= '0;
    else
      last_r <= bus;
  end
  assign alu_upd_o = upd_i[0];
  assign alu_st_o = bus[3:0];
  assign mult_upd_o = upd_i[1];
  assign mult_ovf_o = bus[AB_MV];
  assign shift_upd_o = upd_i[2];
  assign shift_ovf_o = bus[AB_SV];
  // wire level from both drivers
  assign pin_o = (drv_i & oe_i) | (ext_i & ~oe_i);
endmodule // bcs_unit_model

// [testbench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import bcs_pkg::*;
  logic clk_i, rst_i, ins_call_i, ins_delayed_i;
  logic [RA_W-1:0] reg_addr_i;
  logic [DW-1:0] reg_wdata_i, reg_rdata_o, dag_i;
  logic [6:0] stb;
  logic [KIND_W-1:0] ins_kind_i;
  logic [COND_W-1:0] ins_cond_i;
  logic [AW-1:0] ins_pc_i, ins_imm_i, redirect_addr_o;
  logic [TERM_W-1:0] ins_term_i;
  logic [AST_W-1:0] st;
  logic [NFLAG-1:0] ext, flag_o, flag_oe_o, pin;
  logic alu_upd, mult_upd, shift_upd, mult_ovf, shift_ovf;
  logic [3:0] alu_st;
  logic exec_o, suppress_o, redirect_o, redirect_call_o, flush_o, loop_back_o, loop_exit_o, irq_o;
  int n_mismatch, comparisons;

  bcs_unit_model part_u (.clk_i(clk_i), .rst_i(rst_i), .upd_i(stb[6:4]), .st_i(st), .ext_i(ext),
    .alu_upd_o(alu_upd), .alu_st_o(alu_st), .mult_upd_o(mult_upd), .mult_ovf_o(mult_ovf),
    .shift_upd_o(shift_upd), .shift_ovf_o(shift_ovf), .drv_i(flag_o), .oe_i(flag_oe_o),
    .pin_o(pin));
  bcs_seq dut_u (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(stb[1]), .reg_rd_i(stb[2]), .reg_rdata_o(reg_rdata_o), .alu_upd_i(alu_upd),
    .alu_zero_i(alu_st[0]), .alu_neg_i(alu_st[1]), .alu_ovf_i(alu_st[2]), .alu_carry_i(alu_st[3]),
    .mult_upd_i(mult_upd), .mult_ovf_i(mult_ovf), .shift_upd_i(shift_upd), .shift_ovf_i(shift_ovf),
    .ins_valid_i(stb[0]), .ins_kind_i(ins_kind_i), .ins_cond_i(ins_cond_i), .ins_call_i(ins_call_i),
    .ins_delayed_i(ins_delayed_i), .ins_pc_i(ins_pc_i), .ins_imm_i(ins_imm_i),
    .ins_term_i(ins_term_i), .dag_i(dag_i), .loop_last_i(stb[3]), .exec_o(exec_o),
    .suppress_o(suppress_o), .redirect_o(redirect_o), .redirect_call_o(redirect_call_o),
    .redirect_addr_o(redirect_addr_o), .flush_o(flush_o), .loop_back_o(loop_back_o),
    .loop_exit_o(loop_exit_o), .flag_i(pin), .flag_o(flag_o), .flag_oe_o(flag_oe_o), .irq_o(irq_o));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [AW-1:0] got, input logic [AW-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc();
    @(posedge clk_i);
    #1;
  endtask

  // strobes: 0 issue, 1 write, 2 read, 3 loop end, 4-6 unit loads
  task automatic drive(input logic [6:0] s);
    stb <= s;
    cyc();
  endtask

  task automatic wr(input logic [RA_W-1:0] a, input logic [DW-1:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    drive(7'h02);
  endtask

  task automatic rdc(input logic [RA_W-1:0] a, input logic [DW-1:0] exp);
    reg_addr_i <= a;
    drive(7'h04);
    chk(reg_rdata_o, exp);
  endtask

  task automatic issue(input logic [KIND_W-1:0] k, input logic [COND_W-1:0] c);
    ins_kind_i <= k;
    ins_cond_i <= c;
    ins_call_i <= 1'b0;
    ins_delayed_i <= 1'b0;
    drive(7'h01);
  endtask

  function automatic logic cexp(input logic [AST_W-1:0] s, input logic [COND_W-1:0] c);
    logic lt;
    lt = s[AB_N] ^ s[AB_V];
    case (c)
      C_EQ: return s[AB_Z];
      C_NE: return !s[AB_Z];
      C_GT: return !(lt | s[AB_Z]);
      C_LE: return lt | s[AB_Z];
      C_LT: return lt;
      C_GE: return !lt;
      C_AV: return s[AB_V];
      C_NAV: return !s[AB_V];
      C_AC: return s[AB_C];
      C_NAC: return !s[AB_C];
      C_SW: return s[AB_N];
      C_NSW: return !s[AB_N];
      C_MV: return s[AB_MV];
      C_NMV: return !s[AB_MV];
      C_TRUE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  task automatic br(input logic [KIND_W-1:0] k, input logic cl, input logic dl,
    input logic [COND_W-1:0] c, input logic [AW-1:0] pc, input logic [AW-1:0] im,
    input logic [AW-1:0] ex);
    int lat;
    lat = dl ? 2 : 4;
    ins_kind_i <= k;
    ins_cond_i <= c;
    ins_call_i <= cl;
    ins_delayed_i <= dl;
    ins_pc_i <= pc;
    ins_imm_i <= im;
    drive(7'h01);
    for (int i = 1; i <= lat; i++)
    begin
      chk(redirect_o, i == lat);
      if (i < lat)
      begin
        ins_kind_i <= K_OP;
        ins_cond_i <= C_TRUE;
        drive({6'h00, dl});
        if (dl)
          chk(exec_o, 1'b1);
      end
    end
    chk(flush_o, !dl);
    chk(redirect_call_o, cl);
    chk(redirect_addr_o, ex);
  endtask

  task automatic ll(input logic b, input logic x);
    drive(7'h08);
    chk(loop_back_o, b);
    chk(loop_exit_o, x);
  endtask

  task automatic t_regs();
    for (int a = 0; a < 9; a++)
      rdc(a[RA_W-1:0], 16'h0000);
    wr(RA_ARITH_STATUS_REG, 16'hFFDF);
    wr(RA_CC, 16'hFFFF);
    wr(RA_LCNT, 16'h1234);
    wr(RA_FLAG, 16'h00FF);
    rdc(RA_ARITH_STATUS_REG, 16'h001F);
    rdc(RA_CC, 16'h001F);
    rdc(RA_LCNT, 16'h0000);
    rdc(RA_FLAG, 16'h0000);
  endtask

  task automatic t_lat();
    wr(RA_ARITH_STATUS_REG, 16'h0000);
    wr(RA_CC, {11'h000, CC_AS});
    wr(RA_ARITH_STATUS_REG, 16'h0001);
    issue(K_OP, C_EQ);
    chk(suppress_o, 1'b1);
    issue(K_OP, C_EQ);
    chk(exec_o, 1'b1);
  endtask

  task automatic t_conds();
    logic [AST_W-1:0] pats [3];
    logic e;
    pats = '{6'h01, 6'h1E, 6'h0A};
    foreach (pats[p])
    begin
      wr(RA_ARITH_STATUS_REG, {10'h000, pats[p]});
      drive(7'h00);
      for (int c = 0; c < 16; c++)
      begin
        issue(K_OP, c[COND_W-1:0]);
        e = cexp(pats[p], c[COND_W-1:0]);
        chk(exec_o, e);
        chk(suppress_o, !e);
      end
    end
  endtask

  task automatic t_sv();
    wr(RA_ARITH_STATUS_REG, 16'h0000);
    st <= 6'h20;
    drive(7'h40);
    rdc(RA_ARITH_STATUS_REG, 16'h0020);
    wr(RA_CC, {11'h000, CC_SV});
    issue(K_OP, C_SW);
    chk(suppress_o, 1'b1);
    issue(K_OP, C_SW);
    chk(exec_o, 1'b1);
    st <= 6'h00;
    drive(7'h40);
    issue(K_OP, C_SW);
    chk(suppress_o, 1'b1);
  endtask

  task automatic t_br();
    dag_i <= 16'hBEEF;
    rdc(RA_IST, 16'h0008);
    wr(RA_IMASK, 16'h0001);
    br(K_LONG, 1'b1, 1'b0, C_TRUE, 24'h00_0010, 24'hAB_CDEF, 24'hAB_CDEF);
    br(K_J13, 1'b0, 1'b0, C_TRUE, 24'h00_1000, 24'h00_1FFF, 24'h00_0FFF);
    br(K_J13, 1'b0, 1'b1, C_NE, 24'h00_1000, 24'h00_0FFF, 24'h00_1FFF);
    br(K_JC16, 1'b1, 1'b0, 4'hF, 24'h12_0000, 24'h00_8000, 24'h11_8000);
    br(K_JC16, 1'b0, 1'b1, C_TRUE, 24'h12_0000, 24'h00_7FFF, 24'h12_7FFF);
    br(K_IND, 1'b1, 1'b1, C_NE, 24'h34_0010, 24'h00_0000, 24'h34_BEEF);
    issue(K_J13, 4'hF);
    chk(suppress_o, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      drive(7'h00);
      chk(redirect_o, 1'b0);
    end
    chk(irq_o, 1'b1);
    rdc(RA_IST, 16'h0001);
    wr(RA_IMASK, 16'h0000);
    drive(7'h00);
    chk(irq_o, 1'b0);
  endtask

  task automatic t_loop();
    ins_imm_i <= 24'h00_0002;
    ins_term_i <= 4'h3;
    issue(K_LOOP, C_TRUE);
    ll(1'b0, 1'b0);
    ins_term_i <= TERM_CE;
    issue(K_LOOP, C_TRUE);
    ll(1'b1, 1'b0);
    ll(1'b0, 1'b1);
    ll(1'b0, 1'b0);
    ins_term_i <= TERM_FOREVER;
    issue(K_LOOP, C_TRUE);
    ll(1'b1, 1'b0);
    ll(1'b1, 1'b0);
    chk(irq_o, 1'b0);
    rdc(RA_IST, 16'h0006);
  endtask

  task automatic t_flags();
    ext <= 16'h5AFF;
    wr(RA_FDIR, 16'h00FF);
    wr(RA_FOUT, 16'h00A5);
    repeat (3) drive(7'h00);
    chk(flag_oe_o, 16'h00FF);
    chk(flag_o, 16'h00A5);
    rdc(RA_FLAG, 16'h5AA5);
    wr(RA_CC, 16'h0011);
    drive(7'h00);
    issue(K_OP, C_SW);
    chk(exec_o, 1'b1);
    wr(RA_CC, 16'h0003);
    drive(7'h00);
    issue(K_OP, C_NSW);
    chk(exec_o, 1'b1);
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end

  initial
  begin
    n_mismatch = 0;
    comparisons = 0;
    rst_i = 1'b1;
    stb = '0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    ins_kind_i = '0;
    ins_cond_i = '0;
    ins_call_i = 1'b0;
    ins_delayed_i = 1'b0;
    ins_pc_i = '0;
    ins_imm_i = '0;
    ins_term_i = '0;
    dag_i = '0;
    st = '0;
    ext = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc();
    t_regs();
    t_lat();
    t_conds();
    t_sv();
    t_br();
    t_loop();
    t_flags();
    close_out();
  end
endmodule // tb_top
